//--- hw/bas_pkg.sv
// Package of constants and types for the bridge access status block
package bas_pkg;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam logic [15:0] BRIDGE_BASE = 16'h1000;
  localparam logic [15:0] OFS_IRQ_STATUS = 16'h00c2;
  localparam logic [15:0] OFS_STATUS = 16'h00d0;
  localparam logic [15:0] OFS_RESP_SEL = 16'h00d1;
  localparam logic [15:0] OFS_LAST_ADDR_LO = 16'h00d4;
  localparam logic [15:0] OFS_LAST_ADDR_HI = 16'h00d5;
  localparam logic [15:0] OFS_READ_DATA = 16'h00d8;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int BIT_LAST_LATE = 3;
  localparam int BIT_IN_PROGRESS = 2;
  localparam int BIT_DONE = 1;
  localparam int BIT_RDATA_RDY = 0;
  localparam int BIT_IRQ_LATE = 2;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [1:0] RESP_SEL_RST = 2'h1;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  // Link clock cycles a bridge read may take and still answer in the same command
  localparam logic [3:0] RSP_DEADLINE_CYC = 4'h8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    BAS_RSP_IGNORED = 2'b00,
    BAS_RSP_OK = 2'b01,
    BAS_RSP_FAIL = 2'b10
  } bas_rsp_code_t;

  typedef enum logic [0:0] {
    BAS_LINK_IDLE = 1'b0,
    BAS_LINK_WAIT = 1'b1
  } bas_link_state_t;

  typedef enum logic [1:0] {
    BAS_APB_IDLE = 2'b00,
    BAS_APB_SETUP = 2'b01,
    BAS_APB_ACCESS = 2'b10
  } bas_apb_state_t;

  // Control word command from the link framing logic
  typedef struct packed {
    logic read;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bas_cmd_t;

  // Answer to a control word command
  typedef struct packed {
    bas_rsp_code_t code;
    logic [7:0] rdata;
  } bas_rsp_t;

  // Bridge access handed to the register clock domain
  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bas_req_t;

endpackage : bas_pkg

//--- hw/bas_sync2.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module bas_sync2 (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Level
  input wire logic d,
  output logic q
);
  logic meta_ff;

  // First stage feeds the second stage only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule : bas_sync2

//--- hw/bas_apb_master.sv
// APB master that runs one bridge access per request toggle
`timescale 1ns/1ps
module bas_apb_master (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Handshake with the link domain
  input wire logic req_tgl,
  input wire bas_pkg::bas_req_t req,
  output logic ack_tgl_ff,
  output logic [7:0] ack_rdata_ff,
  // APB
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [15:0] paddr,
  output logic [7:0] pwdata,
  input wire logic [7:0] prdata,
  input wire logic pready
);
  bas_pkg::bas_apb_state_t state_ff;
  logic req_sync;
  logic req_seen_ff;
  bas_pkg::bas_req_t req_ff;

  bas_sync2 u_req_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(req_tgl),
    .q(req_sync)
  );

  // Request fields are held still by the link side until the answer toggles back
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_seen_ff <= 1'b0;
      req_ff <= '0;
    end else if (state_ff == bas_pkg::BAS_APB_IDLE && req_sync != req_seen_ff) begin
      req_seen_ff <= req_sync;
      req_ff <= req;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= bas_pkg::BAS_APB_IDLE;
    end else begin
      case (state_ff)
        bas_pkg::BAS_APB_IDLE: begin
          if (req_sync != req_seen_ff) state_ff <= bas_pkg::BAS_APB_SETUP;
        end
        bas_pkg::BAS_APB_SETUP: state_ff <= bas_pkg::BAS_APB_ACCESS;
        bas_pkg::BAS_APB_ACCESS: begin
          if (pready) state_ff <= bas_pkg::BAS_APB_IDLE;
        end
        default: state_ff <= bas_pkg::BAS_APB_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_tgl_ff <= 1'b0;
      ack_rdata_ff <= bas_pkg::DATA_RST;
    end else if (state_ff == bas_pkg::BAS_APB_ACCESS && pready) begin
      ack_tgl_ff <= ~ack_tgl_ff;
      if (!req_ff.write) ack_rdata_ff <= prdata;
    end
  end

  assign psel = (state_ff != bas_pkg::BAS_APB_IDLE);
  assign penable = (state_ff == bas_pkg::BAS_APB_ACCESS);
  assign pwrite = req_ff.write;
  assign paddr = req_ff.addr;
  assign pwdata = req_ff.wdata;
endmodule : bas_apb_master

//--- hw/bas_bridge_access_status.sv
// Control word bridge front end with its access status flags
`timescale 1ns/1ps
module bas_bridge_access_status (
  // Register side clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link clock
  input wire logic link_clk,
  // Control word commands
  input wire logic cmd_valid,
  input wire bas_pkg::bas_cmd_t cmd,
  output logic rsp_valid_ff,
  output bas_pkg::bas_rsp_t rsp_ff,
  // Internal APB
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [15:0] paddr,
  output logic [7:0] pwdata,
  input wire logic [7:0] prdata,
  input wire logic pready,
  // Status flags as levels
  output logic [7:0] status
);

  // ****************************************************************
  // Address decoding
  // ****************************************************************
  function automatic logic is_bridge(input logic [15:0] addr);
    is_bridge = (addr >= bas_pkg::BRIDGE_BASE);
  endfunction : is_bridge

  // Write of one local register by a command
  function automatic logic local_write(input bas_pkg::bas_cmd_t c, input logic [15:0] ofs);
    local_write = !c.read && (c.addr == ofs);
  endfunction : local_write

  // ****************************************************************
  // State
  // ****************************************************************
  bas_pkg::bas_link_state_t state_ff;
  bas_pkg::bas_link_state_t nxt_state;
  logic [3:0] wait_cnt_ff;
  logic last_late_ff;
  logic in_progress_ff;
  logic done_ff;
  logic rdata_rdy_ff;
  logic irq_late_ff;
  logic [1:0] resp_sel_ff;
  logic [15:0] last_addr_ff;
  logic [7:0] read_data_ff;
  logic req_tgl_ff;
  bas_pkg::bas_req_t req_ff;
  logic ack_tgl;
  logic ack_sync;
  logic ack_seen_ff;
  logic [7:0] ack_rdata;
  logic ack_evt;
  logic cmd_take;
  logic cmd_bridge;
  logic reuse_hit;
  logic start_access;
  logic busy_refuse;
  logic in_time;
  logic late_evt;
  logic late_complete;
  logic nxt_rsp_valid;
  bas_pkg::bas_rsp_t nxt_rsp;
  logic [7:0] local_rdata;
  logic access_end;
  logic read_end;
  logic irq_clear;
  logic sel_write;

  // ****************************************************************
  // Domain crossing
  // ****************************************************************
  bas_apb_master u_apb (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .req_tgl(req_tgl_ff),
    .req(req_ff),
    .ack_tgl_ff(ack_tgl),
    .ack_rdata_ff(ack_rdata),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready)
  );

  bas_sync2 u_ack_sync (
    .clk(link_clk),
    .rst_n(rst_n),
    .d(ack_tgl),
    .q(ack_sync)
  );

  // Returned data is stable from the answer toggle until the next request
  assign ack_evt = (ack_sync != ack_seen_ff);

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_seen_ff <= 1'b0;
    end else begin
      ack_seen_ff <= ack_sync;
    end
  end

  // ****************************************************************
  // Command decode
  // ****************************************************************
  // Commands arriving while a read waits for its deadline are dropped
  assign cmd_take = cmd_valid && (state_ff == bas_pkg::BAS_LINK_IDLE);
  assign cmd_bridge = cmd_take && is_bridge(cmd.addr);
  assign reuse_hit = cmd_bridge && cmd.read && rdata_rdy_ff
    && (cmd.addr == last_addr_ff);
  assign busy_refuse = cmd_bridge && in_progress_ff && !reuse_hit;
  assign start_access = cmd_bridge && !in_progress_ff && !reuse_hit;
  assign in_time = (state_ff == bas_pkg::BAS_LINK_WAIT) && ack_evt;
  assign late_evt = (state_ff == bas_pkg::BAS_LINK_WAIT) && !ack_evt
    && (wait_cnt_ff == bas_pkg::RSP_DEADLINE_CYC - 4'h1);
  assign late_complete = ack_evt && (state_ff == bas_pkg::BAS_LINK_IDLE) && in_progress_ff;
  assign access_end = in_time || late_complete;
  assign read_end = access_end && !req_ff.write;
  assign irq_clear = cmd_take && local_write(cmd, bas_pkg::OFS_IRQ_STATUS)
    && cmd.wdata[bas_pkg::BIT_IRQ_LATE];
  assign sel_write = cmd_take && local_write(cmd, bas_pkg::OFS_RESP_SEL);

  // ****************************************************************
  // Request toward the APB side
  // ****************************************************************
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_tgl_ff <= 1'b0;
      req_ff <= '0;
    end else if (start_access) begin
      req_tgl_ff <= ~req_tgl_ff;
      req_ff.write <= ~cmd.read;
      req_ff.addr <= cmd.addr;
      req_ff.wdata <= cmd.wdata;
    end
  end

  // ****************************************************************
  // Deadline tracking
  // ****************************************************************
  // Eight cycles cover both synchronisers and a zero-wait APB read at any phase
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      bas_pkg::BAS_LINK_IDLE: begin
        if (start_access && cmd.read) nxt_state = bas_pkg::BAS_LINK_WAIT;
      end
      bas_pkg::BAS_LINK_WAIT: begin
        if (in_time || late_evt) nxt_state = bas_pkg::BAS_LINK_IDLE;
      end
      default: nxt_state = bas_pkg::BAS_LINK_IDLE;
    endcase
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= bas_pkg::BAS_LINK_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt_ff <= 4'h0;
    end else if (state_ff == bas_pkg::BAS_LINK_WAIT) begin
      wait_cnt_ff <= wait_cnt_ff + 4'h1;
    end else begin
      wait_cnt_ff <= 4'h0;
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_late_ff <= 1'b0;
    end else if (start_access) begin
      last_late_ff <= 1'b0;
    end else if (late_evt) begin
      last_late_ff <= 1'b1;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_progress_ff <= 1'b0;
    end else if (start_access) begin
      in_progress_ff <= 1'b1;
    end else if (access_end) begin
      in_progress_ff <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
    end else if (start_access || reuse_hit) begin
      done_ff <= 1'b0;
    end else if (access_end) begin
      done_ff <= 1'b1;
    end
  end

  // Any finished read is kept until the next bridge read, so one reread of the same address needs no fetch
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_rdy_ff <= 1'b0;
    end else if (cmd_bridge && cmd.read) begin
      rdata_rdy_ff <= 1'b0;
    end else if (read_end) begin
      rdata_rdy_ff <= 1'b1;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_addr_ff <= bas_pkg::ADDR_RST;
      read_data_ff <= bas_pkg::DATA_RST;
    end else if (read_end) begin
      last_addr_ff <= req_ff.addr;
      read_data_ff <= ack_rdata;
    end
  end

  // ****************************************************************
  // Local register writes
  // ****************************************************************

  // Set wins over a same-cycle clear
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_late_ff <= 1'b0;
    end else if (late_evt) begin
      irq_late_ff <= 1'b1;
    end else if (irq_clear) begin
      irq_late_ff <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_sel_ff <= bas_pkg::RESP_SEL_RST;
    end else if (sel_write) begin
      resp_sel_ff <= cmd.wdata[1:0];
    end
  end

  always_comb begin
    status = bas_pkg::STATUS_RST;
    status[bas_pkg::BIT_LAST_LATE] = last_late_ff;
    status[bas_pkg::BIT_IN_PROGRESS] = in_progress_ff;
    status[bas_pkg::BIT_DONE] = done_ff;
    status[bas_pkg::BIT_RDATA_RDY] = rdata_rdy_ff;
  end

  // ****************************************************************
  // Local register reads
  // ****************************************************************
  always_comb begin
    local_rdata = 8'h00;
    case (cmd.addr)
      bas_pkg::OFS_STATUS: local_rdata = status;
      bas_pkg::OFS_IRQ_STATUS: local_rdata[bas_pkg::BIT_IRQ_LATE] = irq_late_ff;
      bas_pkg::OFS_RESP_SEL: local_rdata[1:0] = resp_sel_ff;
      bas_pkg::OFS_LAST_ADDR_LO: local_rdata = last_addr_ff[7:0];
      bas_pkg::OFS_LAST_ADDR_HI: local_rdata = last_addr_ff[15:8];
      bas_pkg::OFS_READ_DATA: local_rdata = read_data_ff;
      default: local_rdata = 8'h00;
    endcase
  end

  // ****************************************************************
  // Answers
  // ****************************************************************
  always_comb begin
    nxt_rsp_valid = 1'b0;
    nxt_rsp.code = bas_pkg::BAS_RSP_OK;
    nxt_rsp.rdata = 8'h00;
    if (in_time) begin
      nxt_rsp_valid = 1'b1;
      nxt_rsp.rdata = ack_rdata;
    end else if (late_evt) begin
      nxt_rsp_valid = 1'b1;
      // Reserved select value answers as ignored
      case (resp_sel_ff)
        2'h1: nxt_rsp.code = bas_pkg::BAS_RSP_OK;
        2'h2: nxt_rsp.code = bas_pkg::BAS_RSP_FAIL;
        default: nxt_rsp.code = bas_pkg::BAS_RSP_IGNORED;
      endcase
    end else if (cmd_take) begin
      if (reuse_hit) begin
        nxt_rsp_valid = 1'b1;
        nxt_rsp.rdata = read_data_ff;
      end else if (busy_refuse) begin
        nxt_rsp_valid = 1'b1;
        nxt_rsp.code = bas_pkg::BAS_RSP_FAIL;
      end else if (start_access) begin
        // Writes are posted; reads answer from the deadline logic
        nxt_rsp_valid = ~cmd.read;
      end else begin
        nxt_rsp_valid = 1'b1;
        if (cmd.read) nxt_rsp.rdata = local_rdata;
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_ff <= 1'b0;
      rsp_ff <= '0;
    end else begin
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_ff <= nxt_rsp;
    end
  end

endmodule : bas_bridge_access_status

//--- bench/bas_apb_slave.sv
// APB register space model that answers bridge accesses with set wait states
`timescale 1ns/1ps
module bas_apb_slave (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [7:0] pwdata,
  output logic [7:0] prdata,
  output logic pready,
  // Wait states before pready
  input wire logic [7:0] wait_cyc
);
  logic [7:0] mem [16];
  logic [7:0] cnt_ff;
  logic [7:0] last_ff;
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 8'ha0 + 8'(i);
    end
  end
  assign pready = psel && penable && (cnt_ff >= wait_cyc);
  // Released bus shows the inverse of its last value, never a steady guess
  assign prdata = (pready && !pwrite) ? mem[paddr[3:0]] : ~last_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 8'h00;
      last_ff <= 8'h00;
    end else begin
      last_ff <= prdata;
      cnt_ff <= (psel && penable && !pready) ? cnt_ff + 8'h01 : 8'h00;
      if (pready && pwrite) begin
        mem[paddr[3:0]] <= pwdata;
      end
    end
  end
endmodule : bas_apb_slave

//--- bench/bas_status_checker.sv
// Checker of status flags, command answers and APB phases
`timescale 1ns/1ps
module bas_status_checker (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  // Commands
  input wire logic cmd_valid,
  input wire bas_pkg::bas_cmd_t cmd,
  input wire logic rsp_valid_ff,
  input wire bas_pkg::bas_rsp_t rsp_ff,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [7:0] pwdata,
  input wire logic [7:0] prdata,
  input wire logic pready,
  // Flags
  input wire logic [7:0] status
);
  logic br_go;
  logic lc_go;
  logic br_hit;
  logic br_start;
  logic [15:0] rd_addr_ff;
  // Idle bridge only: a waiting read drops commands
  assign br_go = cmd_valid && (cmd.addr >= bas_pkg::BRIDGE_BASE) && !status[2];
  assign lc_go = cmd_valid && (cmd.addr < bas_pkg::BRIDGE_BASE) && !status[2];
  // A reread of a kept address answers at once and starts no fetch
  assign br_hit = cmd.read && status[0] && (cmd.addr == rd_addr_ff);
  assign br_start = br_go && !br_hit;
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_addr_ff <= 16'h0000;
    end else if (br_start && cmd.read) begin
      rd_addr_ff <= cmd.addr;
    end
  end
  reserved_zero_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    status[7:4] == 4'h0) else $error("status upper bits not zero");
  local_stable_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    lc_go |=> $stable(status) && rsp_valid_ff) else $error("local access moved flags");
  busy_start_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    br_start |=> status[2] && !status[1] && !status[3]) else $error("bridge start flags wrong");
  reuse_answer_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    br_go && br_hit |=> rsp_valid_ff && status[1:0] == 2'b00)
    else $error("reread not answered from kept data");
  rdy_clear_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    cmd_valid && cmd.read && (cmd.addr >= bas_pkg::BRIDGE_BASE) |=> !status[0])
    else $error("read valid not cleared");
  read_answer_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    br_start && cmd.read |-> ##[2:9] rsp_valid_ff) else $error("bridge read not answered");
  done_busy_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    status[2] |-> !status[1]) else $error("done set while busy");
  late_busy_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    $rose(status[3]) |-> status[2] && !status[0]) else $error("late flag without fetch");
  apb_setup_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(psel) |-> !penable ##1 (psel && penable)) else $error("APB setup phase wrong");
  apb_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    psel && penable && !pready |=> psel && penable && $stable(paddr) && $stable(pwrite))
    else $error("APB access not held");
  late_seen_c: cover property (@(posedge link_clk) $rose(status[3]));
  rdy_seen_c: cover property (@(posedge link_clk) $rose(status[0]));
  reuse_seen_c: cover property (@(posedge link_clk) br_go && br_hit);
  fail_seen_c: cover property (@(posedge link_clk)
    rsp_valid_ff && rsp_ff.code == bas_pkg::BAS_RSP_FAIL);
endmodule : bas_status_checker

bind bas_bridge_access_status bas_status_checker bas_status_checker_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .cmd_valid(cmd_valid),
  .cmd(cmd), .rsp_valid_ff(rsp_valid_ff), .rsp_ff(rsp_ff), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .status(status));

//--- bench/testbench.sv
// Self-checking bench: commands from the manager side, APB model behind
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  bas_pkg::bas_cmd_t cmd = '0;
  logic rsp_valid_ff;
  bas_pkg::bas_rsp_t rsp_ff;
  logic psel, penable, pwrite, pready;
  logic [15:0] paddr;
  logic [7:0] pwdata, prdata, status;
  logic [7:0] wait_cyc = 8'h00;
  bas_pkg::bas_rsp_t r;
  int fail_count = 0;
  int compares = 0;
  always #12.5 ref_clk = ~ref_clk;
  always #15 link_clk = ~link_clk;
  bas_bridge_access_status bas_bridge_access_status_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd(cmd),
    .rsp_valid_ff(rsp_valid_ff), .rsp_ff(rsp_ff), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .status(status));
  bas_apb_slave bas_apb_slave_inst (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .wait_cyc(wait_cyc));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic give_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check
  // One pulse of cmd_valid, then a bounded wait for the answer
  task automatic send(input logic rd, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge link_clk);
    #1;
    cmd_valid = 1'b1;
    cmd = '{read: rd, addr: a, wdata: d};
    @(posedge link_clk);
    #1;
    cmd_valid = 1'b0;
    while (rsp_valid_ff !== 1'b1 && n < 40) begin
      @(posedge link_clk);
      #1;
      n++;
    end
    if (n == 40) begin
      fail_count++;
      give_verdict();
    end
    r = rsp_ff;
  endtask : send
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    while (status[b] !== v && n < 200) begin
      @(posedge link_clk);
      #1;
      n++;
    end
    if (n == 200) begin
      fail_count++;
      give_verdict();
    end
  endtask : poll
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic s_reset();
    check(status, 8'h00);
    send(1'b0, 16'h00d0, 8'hff);
    send(1'b1, 16'h00d0, 8'h00);
    check(r.rdata, 8'h00);
    send(1'b1, 16'h00d1, 8'h00);
    check(r.rdata, 8'h01);
  endtask : s_reset
  // Also follows a late read, so the late flag must be gone
  task automatic s_fast();
    wait_cyc = 8'h00;
    send(1'b1, 16'h1011, 8'h00);
    check({6'h00, r.code}, {6'h00, bas_pkg::BAS_RSP_OK});
    check(r.rdata, 8'ha1);
    check(status, 8'h03);
    send(1'b1, 16'h0050, 8'h00);
    check(status, 8'h03);
  endtask : s_fast
  task automatic s_write();
    send(1'b0, 16'h1022, 8'h3c);
    check({6'h00, r.code}, {6'h00, bas_pkg::BAS_RSP_OK});
    poll(2, 1'b0);
    check(status & 8'h0e, 8'h02);
    send(1'b1, 16'h1022, 8'h00);
    check(r.rdata, 8'h3c);
    send(1'b1, 16'h1022, 8'h00);
    check(r.rdata, 8'h3c);
    check(status, 8'h00);
  endtask : s_write
  task automatic s_late(input logic [1:0] sel, input logic [7:0] k);
    logic [15:0] a;
    a = 16'h1043 + {8'h00, k};
    wait_cyc = 8'd40;
    send(1'b0, 16'h00d1, {6'h00, sel});
    send(1'b1, a, 8'h00);
    check({6'h00, r.code}, (sel == 2'b11) ? 8'h00 : {6'h00, sel});
    check(status, 8'h0c);
    send(1'b1, 16'h00c2, 8'h00);
    check(r.rdata, 8'h04);
    if (k == 8'h00) begin
      send(1'b0, 16'h1030, 8'h11);
      check({6'h00, r.code}, {6'h00, bas_pkg::BAS_RSP_FAIL});
    end
    poll(0, 1'b1);
    check(status, 8'h0b);
    send(1'b1, 16'h00d8, 8'h00);
    check(r.rdata, 8'ha3 + k);
    send(1'b1, 16'h00d4, 8'h00);
    check(r.rdata, a[7:0]);
    send(1'b1, 16'h00d5, 8'h00);
    check(r.rdata, a[15:8]);
    send(1'b1, a, 8'h00);
    check(r.rdata, 8'ha3 + k);
    check(status & 8'h03, 8'h00);
    send(1'b0, 16'h00c2, 8'h04);
    send(1'b1, 16'h00c2, 8'h00);
    check(r.rdata, 8'h00);
  endtask : s_late
  initial begin
    repeat (5) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    s_reset();
    s_fast();
    s_write();
    s_late(2'b00, 8'h00);
    s_late(2'b01, 8'h01);
    s_late(2'b10, 8'h02);
    s_late(2'b11, 8'h03);
    s_fast();
    give_verdict();
  end
endmodule : testbench
